// ---- hdl/gmo_ctrl.sv ----
// gmo_ctrl: channel group message copy, frame-loss and subchannel control.
// assumes: APB master on clk; frame pins asynchronous; transmit descriptor,
// receive error and channel mode inputs come from logic on clk.
//
// Functional notes
// - with copy on, the config of a transmit descriptor with end-of-message set is stored and used.
// - the stored config drives idle code, pad fill and retransmit for the message.
// - host writes to the message config are always taken, copy on or off.
// - with alignment mask clear, each alignment change writes a descriptor.
// - with alignment mask set, an alignment change writes no descriptor.
// - with frame-loss mask clear, frame loss and regain each write a descriptor.
// - with frame-loss mask set, frame loss and regain write no descriptor.
// - any receive error during frame loss is reported as a frame-loss error.
// - with abort off, reception carries on through frame loss.
// - with abort on, all channels abort reception while frame is lost.
// - with abort on, HDLC reception resumes by itself once the frame returns.
// - with abort on, transparent channels are deactivated at frame loss.
// - with subchannel off clear, slots with subchannel enable are subchanneled.
// - with subchannel off set, no slot is subchanneled.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module gmo_ctrl
  import gmo_pkg::*;
#(
  parameter int unsigned NUM_CHAN = 32,
  parameter int unsigned NUM_SLOT = 32
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       irq,
  input  wire logic                  frameLossPin,
  input  wire logic                  alignChangePin,
  input  wire logic                  txDescValid,
  input  wire logic                  txDescEom,
  input  wire logic [MSG_W-1:0]      txDescCfg,
  input  wire logic                  rxErrValid,
  input  wire gmo_err_t              rxErrCode,
  input  wire logic [NUM_CHAN-1:0]   chanTransparent,
  output logic [MSG_IDLE_W-1:0]      idleCode,
  output logic                       padFill,
  output logic                       retransmit,
  output logic                       irqDescValid,
  output gmo_evt_t                   irqDescEvt,
  output gmo_err_t                   irqDescErr,
  output logic                       rxStatValid,
  output gmo_err_t                   rxStatCode,
  output logic                       rxAbortAll,
  output logic [NUM_CHAN-1:0]        chanActive,
  output logic [NUM_SLOT-1:0]        subchEffective
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (NUM_CHAN < 1 || NUM_CHAN > 32) begin : g_chk_chan
    $error("NUM_CHAN must be 1..32");
  end
  if (NUM_SLOT < 1 || NUM_SLOT > 32) begin : g_chk_slot
    $error("NUM_SLOT must be 1..32");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic                copyOn;
    logic                maskAlign;
    logic                maskLoss;
    logic                abortOn;
    logic                subchOff;
    logic [MSG_W-1:0]    msgCfg;
    logic [ST_W-1:0]     mask;
    logic [NUM_CHAN-1:0] chanActive;
    logic [NUM_SLOT-1:0] subchEn;
    logic [NUM_SLOT-1:0] subchEff;
    logic [EVT_N-1:0]    pend;
    gmo_err_t            pendErr;
    logic                descValid;
    gmo_evt_t            descEvt;
    gmo_err_t            descErr;
    logic                rxStatValid;
    gmo_err_t            rxStatCode;
    logic                rxAbortAll;
    logic                lossPrev;
    logic                alignPrev;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic                irq;
  } gmo_state_t;

  gmo_state_t          stQ;
  gmo_state_t          stD;
  logic                lossSync;
  logic                alignSync;
  logic [ST_W-1:0]     statBits;
  logic [ST_W-1:0]     statSet;
  logic [ST_W-1:0]     statClr;
  logic                wrDone;
  logic                lossRise;
  logic                lossFall;
  logic                alignRise;
  logic                copyEv;
  logic [EVT_N-1:0]    newPend;
  gmo_err_t            subErr;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_CFG, OFF_MSGCFG, OFF_STAT, OFF_MASK,
      OFF_CHANACT, OFF_SUBCHEN, OFF_LIVE: isMapped = 1'b1;
      default:                            isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic wrHit(input logic w, input logic [ADDR_W-1:0] off);
    wrHit = w && (paddr == off);
  endfunction

  // lowest pending event is emitted first
  function automatic gmo_evt_t firstPend(input logic [EVT_N-1:0] v);
    firstPend = EVT_ALIGN;
    for (int i = EVT_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        firstPend = gmo_evt_t'(i[1:0]);
      end
    end
  endfunction

  // ****************************************************************
  // pin synchronisers and sticky status
  // ****************************************************************
  gmo_sync #(
    .W (2)
  ) u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .dataIn  ({frameLossPin, alignChangePin}),
    .dataOut ({lossSync, alignSync})
  );

  gmo_sticky #(
    .W (ST_W)
  ) u_sticky (
    .clk      (clk),
    .rstn     (rstn),
    .setVec   (statSet),
    .clrVec   (statClr),
    .statBits (statBits)
  );

  // ****************************************************************
  // event detection
  // ****************************************************************
  // edges look at the second sync stage only
  assign wrDone    = psel & penable & stQ.pready & pwrite;
  assign lossRise  = lossSync & ~stQ.lossPrev;
  assign lossFall  = ~lossSync & stQ.lossPrev;
  assign alignRise = alignSync & ~stQ.alignPrev;
  assign copyEv    = txDescValid & txDescEom & stQ.copyOn;
  assign subErr    = lossSync ? ERR_FRAME_LOSS : rxErrCode;

  // descriptor requests; receive errors are never masked
  assign newPend[EVT_ALIGN]  = alignRise & ~stQ.maskAlign;
  assign newPend[EVT_LOSS]   = lossRise & ~stQ.maskLoss;
  assign newPend[EVT_REGAIN] = lossFall & ~stQ.maskLoss;
  assign newPend[EVT_RXERR]  = rxErrValid;

  // status bits record every event, masks only gate the irq line
  always_comb begin
    statSet           = '0;
    statSet[ST_ALIGN]  = alignRise;
    statSet[ST_LOSS]   = lossRise;
    statSet[ST_REGAIN] = lossFall;
    statSet[ST_RXERR]  = rxErrValid;
    statSet[ST_COPY]   = copyEv;
    statClr            = wrHit(wrDone, OFF_STAT) ? pwdata[ST_W-1:0] : '0;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    stD           = stQ;
    stD.lossPrev  = lossSync;
    stD.alignPrev = alignSync;

    // apb: one wait state, answer registered, write lands on the final edge
    stD.pready  = 1'b0;
    stD.pslverr = 1'b0;
    if (psel && penable && !stQ.pready) begin
      stD.pready  = 1'b1;
      stD.pslverr = !isMapped(paddr);
      stD.prdata  = '0;
      if (!pwrite) begin
        case (paddr)
          OFF_CFG: begin
            stD.prdata[CFG_COPY_BIT]   = stQ.copyOn;
            stD.prdata[CFG_MALIGN_BIT] = stQ.maskAlign;
            stD.prdata[CFG_MLOSS_BIT]  = stQ.maskLoss;
            stD.prdata[CFG_ABORT_BIT]  = stQ.abortOn;
            stD.prdata[CFG_SUBOFF_BIT] = stQ.subchOff;
          end
          OFF_MSGCFG:  stD.prdata[MSG_W-1:0]    = stQ.msgCfg;
          OFF_STAT:    stD.prdata[ST_W-1:0]     = statBits;
          OFF_MASK:    stD.prdata[ST_W-1:0]     = stQ.mask;
          OFF_CHANACT: stD.prdata[NUM_CHAN-1:0] = stQ.chanActive;
          OFF_SUBCHEN: stD.prdata[NUM_SLOT-1:0] = stQ.subchEn;
          OFF_LIVE: begin
            stD.prdata[LIVE_LOSS_BIT]  = lossSync;
            stD.prdata[LIVE_ABORT_BIT] = stQ.rxAbortAll;
          end
          default:     stD.prdata = '0;
        endcase
      end
    end

    // control bits; a zero copy bit is stored but unsupported
    if (wrHit(wrDone, OFF_CFG)) begin
      stD.copyOn    = pwdata[CFG_COPY_BIT];
      stD.maskAlign = pwdata[CFG_MALIGN_BIT];
      stD.maskLoss  = pwdata[CFG_MLOSS_BIT];
      stD.abortOn   = pwdata[CFG_ABORT_BIT];
      stD.subchOff  = pwdata[CFG_SUBOFF_BIT];
    end
    if (wrHit(wrDone, OFF_MASK)) begin
      stD.mask = pwdata[ST_W-1:0];
    end
    if (wrHit(wrDone, OFF_SUBCHEN)) begin
      stD.subchEn = pwdata[NUM_SLOT-1:0];
    end

    // message config: descriptor copy, then host write on top of it
    if (copyEv) begin
      stD.msgCfg = txDescCfg;
    end
    if (wrHit(wrDone, OFF_MSGCFG)) begin
      stD.msgCfg = pwdata[MSG_W-1:0];
    end

    // channel activation: host reactivates, frame loss may deactivate
    if (wrHit(wrDone, OFF_CHANACT)) begin
      stD.chanActive = pwdata[NUM_CHAN-1:0];
    end
    if (lossRise && stQ.abortOn) begin
      stD.chanActive = stD.chanActive & ~chanTransparent;
    end

    // abort follows the live frame-loss level, so HDLC restarts unaided
    stD.rxAbortAll = lossSync & stQ.abortOn;

    // subchannel enables are overridden group-wide
    stD.subchEff = stD.subchOff ? '0 : stD.subchEn;

    // receive status carries the substituted code
    stD.rxStatValid = rxErrValid;
    stD.rxStatCode  = rxErrValid ? subErr : ERR_NONE;

    // descriptor queue: one per cycle, a new request beats the retire
    stD.descValid = 1'b0;
    stD.descEvt   = EVT_ALIGN;
    stD.descErr   = ERR_NONE;
    stD.pend      = stQ.pend;
    if (|stQ.pend) begin
      stD.descValid = 1'b1;
      stD.descEvt   = firstPend(stQ.pend);
      stD.descErr   = (firstPend(stQ.pend) == EVT_RXERR) ? stQ.pendErr : ERR_NONE;
      stD.pend[firstPend(stQ.pend)] = 1'b0;
    end
    stD.pend = stD.pend | newPend;
    if (rxErrValid) begin
      stD.pendErr = subErr;
    end

    // level interrupt, one cycle behind the status bits
    stD.irq = |(statBits & stQ.mask);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stQ        <= '0;
      stQ.copyOn <= CFG_COPY_RST;
    end else begin
      stQ <= stD;
    end
  end

  // ****************************************************************
  // outputs, all straight from the state register
  // ****************************************************************
  assign prdata         = stQ.prdata;
  assign pready         = stQ.pready;
  assign pslverr        = stQ.pslverr;
  assign irq            = stQ.irq;
  assign idleCode       = stQ.msgCfg[MSG_IDLE_LSB +: MSG_IDLE_W];
  assign padFill        = stQ.msgCfg[MSG_PAD_BIT];
  assign retransmit     = stQ.msgCfg[MSG_RETX_BIT];
  assign irqDescValid   = stQ.descValid;
  assign irqDescEvt     = stQ.descEvt;
  assign irqDescErr     = stQ.descErr;
  assign rxStatValid    = stQ.rxStatValid;
  assign rxStatCode     = stQ.rxStatCode;
  assign rxAbortAll     = stQ.rxAbortAll;
  assign chanActive     = stQ.chanActive;
  assign subchEffective = stQ.subchEff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_msgWrite;
    psel && penable && pready && pwrite && paddr == OFF_MSGCFG;
  endsequence

  sequence s_eomCopy;
    txDescValid && txDescEom && stQ.copyOn
      && !(psel && penable && pready && pwrite && paddr == OFF_MSGCFG);
  endsequence

  a_copy_on_eom: assert property (s_eomCopy |=> idleCode == $past(txDescCfg[MSG_IDLE_W-1:0])
      && retransmit == $past(txDescCfg[MSG_RETX_BIT]))
    else $error("descriptor config not copied");

  a_host_msg_write: assert property (s_msgWrite |=> stQ.msgCfg == $past(pwdata[MSG_W-1:0]))
    else $error("host message write lost");

  // pready is registered, so it shows on the edge after the first access cycle
  a_apb_one_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
    else $error("apb answer not after one wait");

  a_align_desc: assert property (alignRise && !stQ.maskAlign |=> ##[0:3]
      (irqDescValid && irqDescEvt == EVT_ALIGN))
    else $error("alignment descriptor missing");

  a_align_masked: assert property (alignRise && stQ.maskAlign && !stQ.pend[EVT_ALIGN]
      |=> !stQ.pend[EVT_ALIGN])
    else $error("masked alignment queued");

  a_loss_desc: assert property ((lossRise || lossFall) && !stQ.maskLoss |=> ##[0:3]
      (irqDescValid && (irqDescEvt == EVT_LOSS || irqDescEvt == EVT_REGAIN)))
    else $error("frame loss descriptor missing");

  a_loss_masked: assert property (lossRise && stQ.maskLoss && !stQ.pend[EVT_LOSS]
      |=> !stQ.pend[EVT_LOSS])
    else $error("masked frame loss queued");

  a_err_subst: assert property (rxErrValid && lossSync |=> rxStatValid
      && rxStatCode == ERR_FRAME_LOSS)
    else $error("error not reported as frame loss");

  a_no_abort: assert property (!stQ.abortOn |=> !rxAbortAll)
    else $error("abort without abort enable");

  a_abort_all: assert property (lossSync && stQ.abortOn |=> rxAbortAll)
    else $error("reception not aborted");

  a_abort_clear: assert property (!lossSync |=> !rxAbortAll)
    else $error("abort held after frame returned");

  a_transp_off: assert property (lossRise && stQ.abortOn |=>
      (chanActive & $past(chanTransparent)) == '0)
    else $error("transparent channel left active");

  a_subch_gate: assert property (##1 subchEffective == (stQ.subchOff ? '0 : stQ.subchEn))
    else $error("subchannel override wrong");

endmodule // gmo_ctrl

// ---- hdl/gmo_sticky.sv ----
// gmo_sticky: bank of sticky event bits, cleared by writing a one.
// assumes: setVec and clrVec are one-cycle pulses on clk.
module gmo_sticky
  import gmo_pkg::*;
#(
  parameter int unsigned W = ST_W
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] setVec,
  input  wire logic [W-1:0] clrVec,
  output logic      [W-1:0] statBits
);

  typedef struct packed {
    logic [W-1:0] bits;
  } gmo_sticky_t;

  gmo_sticky_t stQ;
  gmo_sticky_t stD;

  // a set in the clearing cycle wins, so no event is lost
  always_comb begin
    stD = stQ;
    for (int i = 0; i < W; i++) begin
      stD.bits[i] = setVec[i] | (stQ.bits[i] & ~clrVec[i]);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign statBits = stQ.bits;

endmodule // gmo_sticky

// ---- hdl/gmo_sync.sv ----
// gmo_sync: two-stage synchroniser for pin levels.
// assumes: inputs are asynchronous to clk; only dataOut is read outside.
module gmo_sync
  import gmo_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] dataIn,
  output logic      [W-1:0] dataOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } gmo_sync_t;

  gmo_sync_t stQ;
  gmo_sync_t stD;

  // stage1 feeds stage2 only, nothing else may look at it
  always_comb begin
    stD        = stQ;
    stD.stage1 = dataIn;
    stD.stage2 = stQ.stage1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign dataOut = stQ.stage2;

endmodule // gmo_sync

// ---- pkg/gmo_pkg.sv ----
// gmo_pkg: register map, field positions, reset values and codes for the
// group message / frame-loss control block.
// assumes: a 32-bit APB slave with byte addresses; one clock domain.
package gmo_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one aligned word each)
  // ****************************************************************
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFF_CFG        = 8'h00; // group control bits 6..2
  localparam logic [7:0]  OFF_MSGCFG     = 8'h04; // message configuration storage
  localparam logic [7:0]  OFF_STAT       = 8'h08; // sticky events, write one to clear
  localparam logic [7:0]  OFF_MASK       = 8'h0C; // interrupt line mask
  localparam logic [7:0]  OFF_CHANACT    = 8'h10; // transparent channel active bits
  localparam logic [7:0]  OFF_SUBCHEN    = 8'h14; // per time slot subchannel enable
  localparam logic [7:0]  OFF_LIVE       = 8'h18; // live state, read only

  // ****************************************************************
  // group control field positions and reset
  // ****************************************************************
  localparam int unsigned CFG_COPY_BIT   = 6;     // msg_cfg_copy_on
  localparam int unsigned CFG_MALIGN_BIT = 5;     // mask_align_change_irq
  localparam int unsigned CFG_MLOSS_BIT  = 4;     // mask_frame_loss_irq
  localparam int unsigned CFG_ABORT_BIT  = 3;     // abort_on_frame_loss
  localparam int unsigned CFG_SUBOFF_BIT = 2;     // subchannel_off
  localparam logic        CFG_COPY_RST   = 1'b1;  // copy disabled is unsupported

  // ****************************************************************
  // message configuration layout
  // ****************************************************************
  localparam int unsigned MSG_W          = 10;
  localparam int unsigned MSG_IDLE_LSB   = 0;
  localparam int unsigned MSG_IDLE_W     = 8;     // non-default idle code
  localparam int unsigned MSG_PAD_BIT    = 8;     // inter-message pad fill
  localparam int unsigned MSG_RETX_BIT   = 9;     // retransmit message

  // ****************************************************************
  // status bits (status and mask share this layout)
  // ****************************************************************
  localparam int unsigned ST_W           = 5;
  localparam int unsigned ST_ALIGN       = 0;
  localparam int unsigned ST_LOSS        = 1;
  localparam int unsigned ST_REGAIN      = 2;
  localparam int unsigned ST_RXERR       = 3;
  localparam int unsigned ST_COPY        = 4;
  localparam int unsigned LIVE_LOSS_BIT  = 0;
  localparam int unsigned LIVE_ABORT_BIT = 1;

  // ****************************************************************
  // descriptor codes
  // ****************************************************************
  localparam int unsigned EVT_N = 4;
  typedef enum logic [1:0] {
    EVT_ALIGN  = 2'h0,
    EVT_LOSS   = 2'h1,
    EVT_REGAIN = 2'h2,
    EVT_RXERR  = 2'h3
  } gmo_evt_t;

  typedef enum logic [2:0] {
    ERR_NONE       = 3'h0,
    ERR_ABORT      = 3'h1,
    ERR_FCS        = 3'h2,
    ERR_LENGTH     = 3'h3,
    ERR_ALIGN      = 3'h4,
    ERR_FRAME_LOSS = 3'h5
  } gmo_err_t;

endpackage

// ---- verif/gmo_ctrl_test.sv ----
// gmo_ctrl_test: self-checking bench for the group control block.
// assumes: gmo_pkg and gmo_far_model compiled first; one 200 MHz clock.
module gmo_ctrl_test
  import gmo_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals
  // ****
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic        txDescValid, txDescEom, rxErrValid, padFill, retransmit;
  logic        irqDescValid, rxStatValid, rxAbortAll, frameLossPin, alignChangePin;
  logic        lossReq, alignReq;
  logic [7:0]  paddr, idleCode;
  logic [9:0]  txDescCfg;
  logic [31:0] pwdata, prdata, rd, v, chanTransparent, chanActive, subchEffective;
  gmo_err_t    rxErrCode, irqDescErr, rxStatCode, lastErr, lastStat, c;
  gmo_evt_t    irqDescEvt;
  int          errors, checked, seed, cyc, nDesc[4];

  gmo_ctrl u_dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .frameLossPin(frameLossPin), .alignChangePin(alignChangePin),
    .txDescValid(txDescValid), .txDescEom(txDescEom), .txDescCfg(txDescCfg),
    .rxErrValid(rxErrValid), .rxErrCode(rxErrCode), .chanTransparent(chanTransparent),
    .idleCode(idleCode), .padFill(padFill), .retransmit(retransmit),
    .irqDescValid(irqDescValid), .irqDescEvt(irqDescEvt), .irqDescErr(irqDescErr),
    .rxStatValid(rxStatValid), .rxStatCode(rxStatCode), .rxAbortAll(rxAbortAll),
    .chanActive(chanActive), .subchEffective(subchEffective));
  gmo_far_model u_far (.clk(clk), .rstn(rstn), .lossReq(lossReq), .alignReq(alignReq),
    .frameLossPin(frameLossPin), .alignChangePin(alignChangePin));

  always #2.5 clk = ~clk;

  // ****
  // expectations, checks and bus tasks
  // ****
  function automatic logic [31:0] expAct(input logic [31:0] a, input logic [31:0] t);
    return a & ~t;
  endfunction
  function automatic logic [31:0] expSub(input logic [31:0] e, input logic off);
    return off ? 32'h0 : e;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // request held until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the cycle watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic txd(input logic end_of_message_flag, input logic [9:0] cf);
    @(posedge clk);
    txDescValid <= 1'b1;
    txDescEom <= end_of_message_flag;
    txDescCfg <= cf;
    @(posedge clk);
    txDescValid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rxe(input gmo_err_t ec);
    @(posedge clk);
    rxErrValid <= 1'b1;
    rxErrCode <= ec;
    @(posedge clk);
    rxErrValid <= 1'b0;
    tick(8);
  endtask
  task automatic loss(input logic l);
    @(posedge clk);
    lossReq <= l;
    tick(12);
  endtask
  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // descriptor monitor and hang guard; a hang counts as a mismatch
  always @(posedge clk) begin
    if (irqDescValid === 1'b1) begin
      nDesc[irqDescEvt]++;
      lastErr = irqDescErr;
    end
    if (rxStatValid === 1'b1)
      lastStat = rxStatCode;
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    {clk, rstn, psel, penable, pwrite, txDescValid, txDescEom, rxErrValid} = '0;
    {lossReq, alignReq, paddr, pwdata, txDescCfg} = '0;
    rxErrCode = ERR_NONE;
    {errors, checked, cyc} = '0;
    nDesc = '{default: 0};
    seed = 9603;
    chanTransparent = $random(seed);
    tick(6);
    rstn <= 1'b1;
    apb(1'b0, OFF_CFG, 32'h0);
    chk("cfg reset", 32'h40, rd);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    // host writes always reach the message config
    for (int i = 0; i < 3; i++) begin
      v = $random(seed) & 32'h3FF;
      apb(1'b1, OFF_MSGCFG, v);
      tick(1);
      chk("msg cfg", v, {22'h0, retransmit, padFill, idleCode});
    end
    // copy only from an end-of-message descriptor
    apb(1'b1, OFF_MASK, 32'h10);
    txd(1'b0, ~v[9:0]);
    chk("no eom", v, {22'h0, retransmit, padFill, idleCode});
    v = $random(seed) & 32'h3FF;
    txd(1'b1, v[9:0]);
    chk("copied", v, {22'h0, retransmit, padFill, idleCode});
    tick(1);
    chk("irq copy", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_STAT, 32'h1F);
    tick(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    // alignment change reported once, then masked
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFF_CFG, m ? 32'h60 : 32'h40);
      @(posedge clk);
      alignReq <= 1'b1;
      tick(1);
      alignReq <= 1'b0;
      tick(12);
      chk("align desc", 32'h1, nDesc[EVT_ALIGN]);
    end
    chk("irq masked", 32'h0, {31'h0, irq});
    // frame loss with descriptors on and abort off
    apb(1'b1, OFF_CFG, 32'h40);
    loss(1'b1);
    chk("no abort", 32'h0, {31'h0, rxAbortAll});
    chk("loss desc", 32'h1, nDesc[EVT_LOSS]);
    rxe(gmo_err_t'(($random(seed) & 3) + 1));
    chk("stat code", ERR_FRAME_LOSS, lastStat);
    chk("desc code", ERR_FRAME_LOSS, lastErr);
    loss(1'b0);
    chk("regain desc", 32'h1, nDesc[EVT_REGAIN]);
    c = gmo_err_t'(($random(seed) & 3) + 1);
    rxe(c);
    chk("plain code", c, lastStat);
    // masked loss with abort on
    apb(1'b1, OFF_CHANACT, 32'hFFFFFFFF);
    apb(1'b1, OFF_CFG, 32'h58);
    loss(1'b1);
    chk("abort all", 32'h1, {31'h0, rxAbortAll});
    chk("chan off", expAct(32'hFFFFFFFF, chanTransparent), chanActive);
    loss(1'b0);
    chk("resumed", 32'h0, {31'h0, rxAbortAll});
    chk("masked", 32'h2, nDesc[EVT_LOSS] + nDesc[EVT_REGAIN]);
    apb(1'b1, OFF_CHANACT, 32'hFFFFFFFF);
    tick(1);
    chk("chan back", 32'hFFFFFFFF, chanActive);
    // group override of the slot subchannel enables
    v = $random(seed);
    apb(1'b1, OFF_SUBCHEN, v);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFF_CFG, s ? 32'h44 : 32'h40);
      tick(1);
      chk("subch", expSub(v, s[0]), subchEffective);
    end
    results();
  end
endmodule // gmo_ctrl_test

// ---- verif/gmo_far_model.sv ----
// gmo_far_model: line-side framer that drives the frame pins.
// assumes: requests come from the bench on the rising edge of clk.
module gmo_far_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic lossReq,
  input  wire logic alignReq,
  output logic      frameLossPin,
  output logic      alignChangePin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] holdQ;
  // an alignment change is held 4 cycles so the synchroniser cannot miss it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      holdQ <= 3'h0;
    end else if (alignReq) begin
      holdQ <= 3'h4;
    end else if (holdQ != 3'h0) begin
      holdQ <= holdQ - 3'h1;
    end
  end
  // loss is a level for as long as the frame stays lost
  assign alignChangePin = (holdQ != 3'h0);
  assign frameLossPin   = lossReq & rstn;
endmodule // gmo_far_model
